// [src/cab_cfg.svh]
// Timing constants, field values and behaviour summary for the contention access and backoff engine
// Behaviour
// - Overheard header for another station loads its duration only if larger than vector.
// - Loaded vector value counts from the end of the overheard PHY header.
// - Header failing its check updates the vector as a zero duration would.
// - Vector counts down with time, stops at zero, resolution one tick.
// - Medium busy on carrier, own tx/rx, own duration, vector nonzero, no access.
// - New frames, zero counter, none pending: transmit after long-space idle.
// - Buffered frames, counter reaching zero in slot: opportunity at next slot boundary.
// - Opportunity ends short space plus guard before access becomes unavailable.
// - Clear-to-train reply suppressed while allocation vector is nonzero.
// - Reply withheld if it cannot finish short space plus guard before unavailability.
// - Next discovery frame starts a medium space after previous one ends.
// - After no-ack or block-ack frame, next frame after medium or short space.
// - Reply to request or ack-asking frame starts one short space after it ends.
// - After expected reply, next frame or retransmission one short space later.
// - Block-ack with good header but bad check: send again a short space later.
// - Spacing that cannot be met ends the transmit opportunity.
// - Backoff loads uniform random value in zero to window; window within limits.
// - Window returns to minimum on good reply, no-ack send or frame discard.
// - Minimum-window backoff on busy arrival, end with nothing left, or no room.
// - Pending transaction not fitting new opportunity: backoff, window unchanged.
// - Missing reply after short space plus ack time: window min(max, 2W+1).
// - Slots start a short space after idle, back to back until busy.
// - Carrier sampled at detect time decides slot; decrement needs long-space idle.
// - Counter freezes on busy and resumes by the same procedure.
// - Access available on discovery channel and in contention blocks only.
`ifndef CAB_CFG_SVH
`define CAB_CFG_SVH
`define CAB_CLK_HZ 20000000
`define CAB_TICK_NS 1000
`define CAB_TICK_DIV ((`CAB_TICK_NS * (`CAB_CLK_HZ / 1000000) + 999) / 1000)
`define CAB_SIFS_US 16'h0003
`define CAB_MIFS_US 16'h0001
`define CAB_LIFS_US 16'h000b
`define CAB_SLOT_US 16'h0008
`define CAB_CCA_US 16'h0004
`define CAB_GUARD_US 16'h0002
`define CAB_IMMACK_US 16'h0005
`define CAB_CW_MIN 8'h07
`define CAB_CW_MAX 8'hff
`define CAB_LFSR_SEED 16'hace1
`define CAB_POL_NOACK 2'h0
`define CAB_POL_IMM 2'h1
`define CAB_POL_BACK 2'h2
`endif

// [src/cab_pkg.sv]
// Types shared by the contention access engine
package cab_pkg;
  typedef enum logic [2:0] {
    CAB_IDLE,
    CAB_CONTEND,
    CAB_TX,
    CAB_WAIT_REPLY,
    CAB_GAP,
    CAB_REPLY
  } cab_state_t;
endpackage

// [src/cab_tick.sv]
// Free-running time-unit tick divider
`timescale 1ns/100ps
`default_nettype none
`include "cab_cfg.svh"
module cab_tick #(
  parameter int unsigned DIV = `CAB_TICK_DIV
) (
  input wire logic clk,
  input wire logic sys_rst,
  output logic tick
);
  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } cab_tick_st_t;
  cab_tick_st_t s_reg;
  cab_tick_st_t s_next;
  always_comb
  begin
    s_next = s_reg;
    s_next.tick = 1'b0;
    if (s_reg.cnt == 16'(DIV - 1))
    begin
      s_next.cnt = 16'h0000;
      s_next.tick = 1'b1;
    end
    else
    begin
      s_next.cnt = s_reg.cnt + 16'h0001;
    end
  end
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end
  assign tick = s_reg.tick;
endmodule
`default_nettype wire

// [src/cab_nav.sv]
// Allocation vector with countdown at tick resolution
`timescale 1ns/100ps
`default_nettype none
`include "cab_cfg.svh"
module cab_nav #(
  parameter int unsigned W = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic tick,
  input wire logic hdr_valid,
  input wire logic hdr_other,
  input wire logic hdr_bad,
  input wire logic [W-1:0] hdr_dur,
  output logic [W-1:0] nav
);
  typedef struct packed {
    logic [W-1:0] nav;
  } cab_nav_st_t;
  cab_nav_st_t s_reg;
  cab_nav_st_t s_next;
  logic [W-1:0] dur_eff;
  always_comb
  begin
    s_next = s_reg;
    dur_eff = hdr_bad ? '0 : hdr_dur;
    if (tick && s_reg.nav != '0)
      s_next.nav = s_reg.nav - 1'b1;
    // Header end marks the count start, so load overrides this tick
    if (hdr_valid && (hdr_other || hdr_bad) && dur_eff > s_next.nav)
      s_next.nav = dur_eff;
  end
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end
  assign nav = s_reg.nav;
endmodule
`default_nettype wire

// [src/cab_top.sv]
// Contention medium access engine: medium status, opportunities, spacing and backoff
`timescale 1ns/100ps
`default_nettype none
`include "cab_cfg.svh"
module cab_top #(
  parameter int unsigned NAV_W = 16,
  parameter logic [7:0] CW_MIN = `CAB_CW_MIN,
  parameter logic [7:0] CW_MAX = `CAB_CW_MAX
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cca_busy_pin,
  input wire logic phy_rx_active_pin,
  input wire logic hdr_valid,
  input wire logic hdr_other,
  input wire logic hdr_bad,
  input wire logic [NAV_W-1:0] hdr_dur,
  input wire logic disc_channel,
  input wire logic dca_block,
  input wire logic [15:0] avail_left,
  input wire logic frame_new,
  input wire logic frame_pending,
  input wire logic frame_discard,
  input wire logic [15:0] txn_len,
  input wire logic [1:0] tx_policy,
  input wire logic tx_disc,
  input wire logic tx_done,
  input wire logic own_dur_active,
  input wire logic reply_ok,
  input wire logic reply_hdr_ok,
  input wire logic reply_fcs_bad,
  input wire logic rx_need_reply,
  input wire logic rx_is_rtt,
  input wire logic [15:0] reply_len,
  input wire logic rx_done,
  output logic tx_start,
  output logic reply_start,
  output logic medium_busy,
  output logic txop_active,
  output logic [7:0] cw,
  output logic [7:0] backoff_cnt
);
  typedef struct packed {
    cab_pkg::cab_state_t st;
    logic cca_s1;
    logic cca_s2;
    logic rx_s1;
    logic rx_s2;
    logic [15:0] idle_us;
    logic [15:0] slot_us;
    logic slot_run;
    logic [15:0] gap_us;
    logic [15:0] gap_tgt;
    logic [15:0] ack_us;
    logic [7:0] cw;
    logic [7:0] bo;
    logic [15:0] lfsr;
    logic txop;
    logic tx_start;
    logic reply_start;
    logic busy;
    logic rx_reply_rtt;
  } cab_st_t;
  cab_st_t s_reg;
  cab_st_t s_next;
  logic tick;
  logic [NAV_W-1:0] nav;
  logic avail;
  logic busy_now;
  logic lifs_ok;
  logic [8:0] cw_dbl;
  logic blk_hdr;

  cab_tick u_tick (
    .clk(clk),
    .sys_rst(sys_rst),
    .tick(tick)
  );

  cab_nav #(.W(NAV_W)) u_nav (
    .clk(clk),
    .sys_rst(sys_rst),
    .tick(tick),
    .hdr_valid(hdr_valid),
    .hdr_other(hdr_other),
    .hdr_bad(hdr_bad),
    .hdr_dur(hdr_dur),
    .nav(nav)
  );

  // Uniform draw in [0, cw]: cw is always 2^n-1, so masking is exact
  function automatic logic [7:0] draw(input logic [15:0] r, input logic [7:0] w);
    draw = r[7:0] & w;
  endfunction

  // Room check against availability end less short space and guard
  function automatic logic fits(input logic [15:0] left, input logic [15:0] need);
    fits = ({1'b0, left} >= ({1'b0, need} + 17'(`CAB_SIFS_US) + 17'(`CAB_GUARD_US)));
  endfunction

  // Doubled window plus one, capped at the maximum
  function automatic logic [7:0] grow_cw(input logic [8:0] dbl);
    grow_cw = (dbl > {1'b0, CW_MAX}) ? CW_MAX : dbl[7:0];
  endfunction

  always_comb
  begin
    s_next = s_reg;
    s_next.tx_start = 1'b0;
    s_next.reply_start = 1'b0;
    s_next.cca_s1 = cca_busy_pin;
    s_next.cca_s2 = s_reg.cca_s1;
    s_next.rx_s1 = phy_rx_active_pin;
    s_next.rx_s2 = s_reg.rx_s1;
    s_next.lfsr = {s_reg.lfsr[14:0], s_reg.lfsr[15] ^ s_reg.lfsr[13] ^ s_reg.lfsr[12] ^ s_reg.lfsr[10]};
    avail = disc_channel | dca_block;
    busy_now = s_reg.cca_s2 | s_reg.rx_s2 | (s_reg.st == cab_pkg::CAB_TX) | (s_reg.st == cab_pkg::CAB_REPLY)
      | own_dur_active | (nav != '0) | ~avail;
    s_next.busy = busy_now;
    lifs_ok = (s_reg.idle_us >= `CAB_LIFS_US);
    cw_dbl = {s_reg.cw, 1'b1};
    // A bad frame check is only flagged once the block-ack header passed
    blk_hdr = reply_hdr_ok | reply_fcs_bad;
    if (busy_now)
      s_next.idle_us = 16'h0000;
    else if (tick && !lifs_ok)
      s_next.idle_us = s_reg.idle_us + 16'h0001;
    // Slot grid: first slot a short space after idle, back to back until busy
    if (busy_now)
    begin
      s_next.slot_run = 1'b0;
      s_next.slot_us = 16'h0000;
    end
    else if (tick)
    begin
      if (!s_reg.slot_run && s_reg.idle_us + 16'h0001 >= `CAB_SIFS_US)
      begin
        s_next.slot_run = 1'b1;
        s_next.slot_us = 16'h0000;
      end
      else if (s_reg.slot_run)
        s_next.slot_us = (s_reg.slot_us == `CAB_SLOT_US - 16'h0001) ? 16'h0000 : s_reg.slot_us + 16'h0001;
    end
    if (frame_discard)
      s_next.cw = CW_MIN;
    case (s_reg.st)
      cab_pkg::CAB_IDLE:
      begin
        if (rx_need_reply)
        begin
          s_next.rx_reply_rtt = rx_is_rtt;
          s_next.gap_us = 16'h0000;
          s_next.st = cab_pkg::CAB_REPLY;
        end
        else if (frame_new && s_reg.bo == 8'h00 && !frame_pending)
        begin
          if (!busy_now && lifs_ok && fits(avail_left, txn_len))
          begin
            s_next.tx_start = 1'b1;
            s_next.txop = 1'b1;
            s_next.st = cab_pkg::CAB_TX;
          end
          else if (busy_now)
          begin
            s_next.cw = CW_MIN;
            s_next.bo = draw(s_reg.lfsr, CW_MIN);
            s_next.st = cab_pkg::CAB_CONTEND;
          end
        end
        else if (frame_pending)
          s_next.st = cab_pkg::CAB_CONTEND;
      end
      cab_pkg::CAB_CONTEND:
      begin
        // Decision at the detect point of each slot, only after long-space idle
        if (tick && s_reg.slot_run && s_reg.slot_us == `CAB_CCA_US && !busy_now && lifs_ok)
        begin
          if (s_reg.bo > 8'h01)
            s_next.bo = s_reg.bo - 8'h01;
          else
            s_next.bo = 8'h00;
        end
        if (tick && s_reg.slot_run && s_reg.slot_us == `CAB_SLOT_US - 16'h0001 && !busy_now
            && s_reg.bo == 8'h00 && lifs_ok)
        begin
          if (fits(avail_left, txn_len))
          begin
            s_next.tx_start = 1'b1;
            s_next.txop = 1'b1;
            s_next.st = cab_pkg::CAB_TX;
          end
          else
            s_next.bo = draw(s_reg.lfsr, s_reg.cw);
        end
      end
      cab_pkg::CAB_TX:
      begin
        if (tx_done)
        begin
          s_next.gap_us = 16'h0000;
          s_next.ack_us = 16'h0000;
          if (tx_policy == `CAB_POL_IMM)
            s_next.st = cab_pkg::CAB_WAIT_REPLY;
          else
          begin
            if (tx_policy == `CAB_POL_NOACK)
              s_next.cw = CW_MIN;
            s_next.gap_tgt = tx_disc ? `CAB_MIFS_US : (tx_policy == `CAB_POL_BACK ? `CAB_SIFS_US : `CAB_MIFS_US);
            s_next.st = cab_pkg::CAB_GAP;
          end
        end
      end
      cab_pkg::CAB_WAIT_REPLY:
      begin
        if (tick)
          s_next.ack_us = s_reg.ack_us + 16'h0001;
        if (reply_ok || blk_hdr)
        begin
          s_next.cw = CW_MIN;
          s_next.gap_tgt = `CAB_SIFS_US;
          s_next.st = cab_pkg::CAB_GAP;
        end
        else if (s_reg.ack_us >= `CAB_SIFS_US + `CAB_IMMACK_US)
        begin
          s_next.cw = grow_cw(cw_dbl);
          s_next.bo = draw(s_reg.lfsr, grow_cw(cw_dbl));
          s_next.txop = 1'b0;
          s_next.st = cab_pkg::CAB_CONTEND;
        end
      end
      cab_pkg::CAB_GAP:
      begin
        if (tick)
          s_next.gap_us = s_reg.gap_us + 16'h0001;
        if (!frame_pending)
        begin
          s_next.cw = CW_MIN;
          s_next.bo = draw(s_reg.lfsr, CW_MIN);
          s_next.txop = 1'b0;
          s_next.st = cab_pkg::CAB_IDLE;
        end
        else if (!fits(avail_left, txn_len + s_reg.gap_tgt) || !avail)
        begin
          s_next.cw = CW_MIN;
          s_next.bo = draw(s_reg.lfsr, CW_MIN);
          s_next.txop = 1'b0;
          s_next.st = cab_pkg::CAB_CONTEND;
        end
        else if (tick && s_reg.gap_us + 16'h0001 == s_reg.gap_tgt)
        begin
          s_next.tx_start = 1'b1;
          s_next.st = cab_pkg::CAB_TX;
        end
      end
      cab_pkg::CAB_REPLY:
      begin
        if (s_reg.rx_reply_rtt && nav != '0)
          s_next.st = cab_pkg::CAB_IDLE;
        else if (!fits(avail_left, reply_len))
          s_next.st = cab_pkg::CAB_IDLE;
        else
        begin
          if (tick)
            s_next.gap_us = s_reg.gap_us + 16'h0001;
          if (tick && s_reg.gap_us + 16'h0001 == `CAB_SIFS_US)
            s_next.reply_start = 1'b1;
          if (rx_done)
            s_next.st = cab_pkg::CAB_IDLE;
        end
      end
      default:
        s_next.st = cab_pkg::CAB_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      s_reg <= '0;
      s_reg.st <= cab_pkg::CAB_IDLE;
      s_reg.cw <= CW_MIN;
      s_reg.lfsr <= `CAB_LFSR_SEED;
      s_reg.busy <= 1'b1;
    end
    else
      s_reg <= s_next;
  end

  assign tx_start = s_reg.tx_start;
  assign reply_start = s_reg.reply_start;
  assign medium_busy = s_reg.busy;
  assign txop_active = s_reg.txop;
  assign cw = s_reg.cw;
  assign backoff_cnt = s_reg.bo;

  a_cw_bounds: assert property (@(posedge clk) disable iff (sys_rst) cw >= CW_MIN && cw <= CW_MAX)
    else $error("window out of limits");
  a_bo_in_cw: assert property (@(posedge clk) disable iff (sys_rst)
    $changed(backoff_cnt) && backoff_cnt > $past(backoff_cnt) |-> backoff_cnt <= cw)
    else $error("backoff above window");
  a_bo_freeze: assert property (@(posedge clk) disable iff (sys_rst)
    s_reg.busy && $past(s_reg.st) == cab_pkg::CAB_CONTEND && s_reg.st == cab_pkg::CAB_CONTEND
    |-> backoff_cnt >= $past(backoff_cnt) || $past(s_reg.st) != s_reg.st)
    else $error("counter moved while busy");
  a_cts_nav: assert property (@(posedge clk) disable iff (sys_rst)
    s_next.reply_start && s_reg.rx_reply_rtt |-> nav == '0)
    else $error("reply despite vector");
  a_busy_nav: assert property (@(posedge clk) disable iff (sys_rst) nav != '0 |=> medium_busy)
    else $error("vector nonzero but idle");
  a_busy_avail: assert property (@(posedge clk) disable iff (sys_rst) !(disc_channel | dca_block) |=> medium_busy)
    else $error("idle while unavailable");
  sequence s_tx_end_noack;
    s_reg.st == cab_pkg::CAB_TX && tx_done && tx_policy == `CAB_POL_NOACK;
  endsequence
  a_noack_cw: assert property (@(posedge clk) disable iff (sys_rst) s_tx_end_noack |=> cw == CW_MIN)
    else $error("window not reset");
  a_start_idle: assert property (@(posedge clk) disable iff (sys_rst)
    tx_start && $past(s_reg.st) == cab_pkg::CAB_IDLE |-> $past(lifs_ok) && !$past(busy_now))
    else $error("start without idle");
  sequence s_reply_missed;
    s_reg.st == cab_pkg::CAB_WAIT_REPLY && !(reply_ok || blk_hdr) && s_reg.ack_us >= `CAB_SIFS_US + `CAB_IMMACK_US;
  endsequence
  a_miss_backoff: assert property (@(posedge clk) disable iff (sys_rst)
    s_reply_missed |=> s_reg.st == cab_pkg::CAB_CONTEND && !txop_active && cw >= $past(cw))
    else $error("no backoff after missing reply");
  a_reply_gate: assert property (@(posedge clk) disable iff (sys_rst)
    reply_start |-> $past(s_reg.st) == cab_pkg::CAB_REPLY && $past(nav == '0 || !s_reg.rx_reply_rtt)
      && $past({1'b0, avail_left} >= {1'b0, reply_len} + 17'(`CAB_SIFS_US) + 17'(`CAB_GUARD_US)))
    else $error("reply sent while it must be withheld");
  sequence s_gap_start;
    tx_start ##0 $past(s_reg.st) == cab_pkg::CAB_GAP;
  endsequence
  a_gap_room: assert property (@(posedge clk) disable iff (sys_rst)
    s_gap_start |-> $past(disc_channel | dca_block))
    else $error("frame started without access");
  sequence s_gap_empty;
    s_reg.st == cab_pkg::CAB_GAP && !frame_pending;
  endsequence
  a_gap_end: assert property (@(posedge clk) disable iff (sys_rst) s_gap_empty |=> !txop_active && !tx_start)
    else $error("opportunity kept with nothing queued");
  a_tx_pulse: assert property (@(posedge clk) disable iff (sys_rst) tx_start |=> !tx_start)
    else $error("start pulse too long");
  a_reply_pulse: assert property (@(posedge clk) disable iff (sys_rst) reply_start |=> !reply_start)
    else $error("reply pulse too long");
endmodule
`default_nettype wire

// [tb/cab_peer.sv]
// Peer MAC model on the shared medium: carrier, request-to-train and immediate ack replies
`timescale 1ns/100ps
`default_nettype none
`include "cab_cfg.svh"
module cab_peer (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic busy_cmd,
  input wire logic rtt_cmd,
  input wire logic ack_en,
  input wire logic tx_done,
  input wire logic [1:0] tx_policy,
  output logic cca_busy_pin,
  output logic phy_rx_active_pin,
  output logic rx_need_reply,
  output logic rx_is_rtt,
  output logic reply_ok
);
  localparam int unsigned US = 20;
  int unsigned cnt_reg;
  assign cca_busy_pin = busy_cmd;
  always_ff @(posedge clk)
  begin
    rx_need_reply <= rtt_cmd;
    rx_is_rtt <= rtt_cmd;
    reply_ok <= 1'b0;
    if (sys_rst)
    begin
      cnt_reg <= 0;
      phy_rx_active_pin <= 1'b0;
    end
    else if (tx_done && ack_en && tx_policy == `CAB_POL_IMM)
      cnt_reg <= 1;
    else if (cnt_reg != 0)
    begin
      cnt_reg <= cnt_reg + 1;
      // Ack goes on air one short space after the frame ends
      phy_rx_active_pin <= (cnt_reg >= `CAB_SIFS_US * US);
      // Short two-tick ack, well inside the missing-reply deadline
      if (cnt_reg == (`CAB_SIFS_US + 2) * US)
      begin
        reply_ok <= 1'b1;
        cnt_reg <= 0;
        phy_rx_active_pin <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// [tb/test_contention_access_backoff.sv]
// Self-checking bench for the contention access engine
`timescale 1ns/100ps
`default_nettype none
`include "cab_cfg.svh"
module test_contention_access_backoff;
  localparam int US = 20;
  logic clk, sys_rst, busy_cmd, rtt_cmd, ack_en, hdr_valid, hdr_other, hdr_bad, disc_channel, dca_block;
  logic frame_new, frame_pending, frame_discard, tx_disc, tx_done, own_dur_active, reply_hdr_ok, reply_fcs_bad;
  logic rx_done, tx_start, reply_start, medium_busy, txop_active, seen;
  logic [15:0] hdr_dur, avail_left, txn_len, reply_len;
  logic [1:0] tx_policy;
  logic [7:0] cw, backoff_cnt;
  wire logic cca_busy_pin, phy_rx_active_pin, rx_need_reply, rx_is_rtt, reply_ok;
  int err_count, n_tests, cyc_count, n;
  cab_peer u_peer (.clk, .sys_rst, .busy_cmd, .rtt_cmd, .ack_en, .tx_done, .tx_policy, .cca_busy_pin,
    .phy_rx_active_pin, .rx_need_reply, .rx_is_rtt, .reply_ok);
  cab_top u_dut (.clk, .sys_rst, .cca_busy_pin, .phy_rx_active_pin, .hdr_valid, .hdr_other, .hdr_bad, .hdr_dur,
    .disc_channel, .dca_block, .avail_left, .frame_new, .frame_pending, .frame_discard, .txn_len, .tx_policy,
    .tx_disc, .tx_done, .own_dur_active, .reply_ok, .reply_hdr_ok, .reply_fcs_bad, .rx_need_reply, .rx_is_rtt,
    .reply_len, .rx_done, .tx_start, .reply_start, .medium_busy, .txop_active, .cw, .backoff_cnt);
  always #25 clk = ~clk;
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Hang guard well above the longest backoff wait
  always @(posedge clk)
  begin
    cyc_count++;
    if (cyc_count == 95000)
    begin
      err_count++;
      conclude();
    end
  end
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic wait_tx(input int lim);
    seen = 1'b0;
    n = -1;
    for (int i = 1; i <= lim && !seen; i++)
    begin
      @(negedge clk);
      seen = (tx_start === 1'b1);
      if (seen)
        n = i;
    end
  endtask
  task automatic wait_rs(input int lim);
    n = -1;
    for (int i = 1; i <= lim; i++)
    begin
      @(negedge clk);
      if (reply_start === 1'b1 && n < 0)
        n = i;
    end
  endtask
  task automatic hdr(input logic [15:0] d, input logic bad);
    hdr_dur = d;
    hdr_bad = bad;
    hdr_valid = 1'b1;
    cyc(1);
    hdr_valid = 1'b0;
    cyc(1);
  endtask
  task automatic frame_out(input logic [1:0] pol);
    tx_policy = pol;
    cyc(2 * US);
    tx_done = 1'b1;
    cyc(1);
    tx_done = 1'b0;
  endtask
  task automatic rtt();
    rtt_cmd = 1'b1;
    cyc(1);
    rtt_cmd = 1'b0;
  endtask
  task automatic t_busy();
    busy_cmd = 1'b1;
    cyc(6);
    chk("busy_cca", 1, medium_busy);
    busy_cmd = 1'b0;
    cyc(6);
    chk("idle", 0, medium_busy);
    own_dur_active = 1'b1;
    cyc(3);
    chk("busy_own", 1, medium_busy);
    own_dur_active = 1'b0;
    disc_channel = 1'b0;
    cyc(3);
    chk("busy_noacc", 1, medium_busy);
    dca_block = 1'b1;
    cyc(3);
    chk("idle_blk", 0, medium_busy);
  endtask
  task automatic t_nav();
    hdr(16'h0014, 1'b0);
    cyc(3);
    chk("nav_busy", 1, medium_busy);
    hdr(16'h0005, 1'b0);
    hdr(16'h0040, 1'b1);
    cyc(15 * US);
    chk("nav_hold", 1, medium_busy);
    cyc(8 * US);
    chk("nav_done", 0, medium_busy);
  endtask
  task automatic t_txop();
    cyc((`CAB_LIFS_US + 2) * US);
    frame_new = 1'b1;
    wait_tx(5);
    frame_new = 1'b0;
    chk("tx_first", 1, seen);
    chk("txop_on", 1, txop_active);
    frame_pending = 1'b1;
    frame_out(`CAB_POL_NOACK);
    wait_tx(3 * US);
    chk("tx_gap", 1, seen && n <= `CAB_MIFS_US * US);
    chk("cw_noack", 16'h0007, cw);
    frame_out(`CAB_POL_BACK);
    wait_tx(4 * US);
    // Free-running tick: a gap may end up to one tick short of nominal
    chk("gap_back", 1, n >= (`CAB_SIFS_US - 1) * US && n <= `CAB_SIFS_US * US + 1);
    tx_disc = 1'b1;
    frame_out(`CAB_POL_BACK);
    tx_disc = 1'b0;
    wait_tx(3 * US);
    chk("gap_disc", 1, seen && n <= `CAB_MIFS_US * US);
    avail_left = txn_len;
    frame_out(`CAB_POL_NOACK);
    wait_tx(3 * US);
    chk("room_end", 0, seen);
    chk("txop_cut", 0, txop_active);
    avail_left = 16'hffff;
    wait_tx(400 * US);
    chk("tx_slot", 1, seen);
    frame_pending = 1'b0;
    frame_out(`CAB_POL_NOACK);
    cyc(3 * US);
    chk("txop_off", 0, txop_active);
    chk("bo_range", 1, backoff_cnt <= cw);
  endtask
  task automatic tx_fail(input logic [7:0] exp);
    wait_tx(400 * US);
    chk("tx_backoff", 1, seen);
    frame_out(`CAB_POL_IMM);
    cyc(10 * US);
    chk("cw_miss", exp, cw);
    chk("bo_range", 1, backoff_cnt <= cw);
  endtask
  task automatic t_retry();
    frame_pending = 1'b1;
    tx_fail(8'h0f);
    tx_fail(8'h1f);
    frame_discard = 1'b1;
    cyc(1);
    frame_discard = 1'b0;
    cyc(2);
    chk("cw_discard", 16'h0007, cw);
    tx_fail(8'h0f);
    ack_en = 1'b1;
    wait_tx(400 * US);
    frame_out(`CAB_POL_IMM);
    wait_tx(12 * US);
    chk("tx_after_ack", 1, seen);
    chk("cw_ack", 16'h0007, cw);
    ack_en = 1'b0;
    frame_out(`CAB_POL_IMM);
    cyc(2 * US);
    {reply_hdr_ok, reply_fcs_bad} = 2'h3;
    cyc(1);
    {reply_hdr_ok, reply_fcs_bad} = 2'h0;
    wait_tx(4 * US);
    chk("tx_fcs_bad", 1, n >= (`CAB_SIFS_US - 1) * US && n <= `CAB_SIFS_US * US + 1);
    frame_pending = 1'b0;
    frame_out(`CAB_POL_NOACK);
    cyc(3 * US);
  endtask
  task automatic t_reply();
    hdr(16'h000a, 1'b0);
    rtt();
    wait_rs(5 * US);
    chk("rtt_nav", 1, n < 0);
    cyc(10 * US);
    rtt();
    wait_rs(6 * US);
    // Reply lands within one tick below the short space, tick being free-running
    chk("rtt_gap", 1, n >= (`CAB_SIFS_US - 1) * US && n <= `CAB_SIFS_US * US + 3);
    rx_done = 1'b1;
    cyc(1);
    rx_done = 1'b0;
    avail_left = `CAB_SIFS_US + `CAB_GUARD_US + reply_len - 16'h0001;
    rtt();
    wait_rs(6 * US);
    chk("reply_room", 1, n < 0);
    avail_left = 16'hffff;
  endtask
  initial
  begin
    {clk, busy_cmd, rtt_cmd, ack_en, hdr_valid, hdr_bad, dca_block, frame_new, frame_pending} = '0;
    {frame_discard, tx_disc, tx_done, own_dur_active, reply_hdr_ok, reply_fcs_bad, rx_done} = '0;
    {sys_rst, hdr_other, disc_channel} = 3'h7;
    {err_count, n_tests, cyc_count} = '0;
    hdr_dur = 16'h0000;
    avail_left = 16'hffff;
    txn_len = 16'h0010;
    reply_len = 16'h0005;
    tx_policy = `CAB_POL_NOACK;
    cyc(5);
    chk("rst_busy", 1, medium_busy);
    chk("rst_cw", 16'h0007, cw);
    chk("rst_bo", 0, backoff_cnt);
    sys_rst = 1'b0;
    cyc(3);
    t_busy();
    t_nav();
    t_txop();
    t_retry();
    t_reply();
    conclude();
  end
endmodule
`default_nettype wire
